/* pkg/sckdr_pkg.sv */
// types shared by the clock delay ramp block
package sckdr_pkg;
    typedef enum logic [1:0] {
        SCKDR_RAMP_IDLE,
        SCKDR_RAMP_WAIT,
        SCKDR_RAMP_STEP
    } sckdr_ramp_state_type;

    typedef enum logic {
        SCKDR_MODE_DUAL_CHANNEL,
        SCKDR_MODE_SINGLE_CHANNEL
    } sckdr_mode_type;
endpackage

/* pkg/sckdr_regs.svh */
// register offsets, field layouts and timing counts of the clock delay ramp block
`ifndef SCKDR_REGS_SVH
`define SCKDR_REGS_SVH

`define SCKDR_ADDR_W          4
`define SCKDR_OFF_DELAY_CTRL  4'h0
`define SCKDR_OFF_COARSE      4'h1
`define SCKDR_OFF_FINE        4'h2
`define SCKDR_OFF_RAMP_CTRL   4'h3
`define SCKDR_OFF_FRAME_CTRL  4'h4
`define SCKDR_OFF_STATUS      4'h5
`define SCKDR_OFF_ACTIVE      4'h6

`define SCKDR_BIT_INVERT      0
`define SCKDR_BIT_DUAL_EDGE   1
`define SCKDR_LSB_DEMUX       2
`define SCKDR_BIT_RAMP_EN     0
`define SCKDR_BIT_RAMP_FAST   1
`define SCKDR_BIT_RAMPING     0
`define SCKDR_BIT_REF_SEEN    1

`define SCKDR_RST_COARSE      8'h00
`define SCKDR_RST_FINE        8'h00
`define SCKDR_RST_DEMUX       2'h0
`define SCKDR_RST_FRAME       8'h04

`define SCKDR_RAMP_PERIOD     9'h100
`define SCKDR_SLOW_STEPS      8'h01
`define SCKDR_FAST_STEPS      8'h04

`endif

/* src/sckdr_delay_ramp.sv */
// aperture delay control: inversion, coarse and fine stages, coarse ramp, reference capture
//
// Functional notes
// - dual-channel mode samples on each rising device clock edge.
// - single-channel mode samples on both clock edges, double rate.
// - device clock also runs digital processing and the output bus.
// - captured reference event resets dividers and strobe generation.
// - reference captured by the same deterministic clock edge, source meets margins.
// - invert control delays sampling by half a clock period.
// - coarse and fine stages each give 256 settings.
// - inversion, coarse and fine act independently and add together.
// - programmed delay shifts all internal clocks and reference capture.
// - with ramp on, active coarse walks gradually to the written value.
// - ramp rate is one or four coarse steps per 256 clocks.
// - each coarse write while ramping starts a new ramp.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "sckdr_regs.svh"
module sckdr_delay_ramp
    import sckdr_pkg::*;
#(
    parameter int DELAY_W = 8,
    parameter int DEMUX_W = 2,
    parameter int FRAME_W = 8,
    parameter int DATA_W  = 8
)
(
    input  wire logic                     clock,
    input  wire logic                     sys_rst,
    input  wire logic [`SCKDR_ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0]        reg_wdata,
    input  wire logic                     reg_write,
    input  wire logic                     reg_read,
    output var  logic [DATA_W-1:0]        reg_rdata,
    input  wire logic                     system_reference,
    output var  logic                     clock_invert_delay,
    output var  logic [DELAY_W-1:0]       coarse_aperture_delay,
    output var  logic [DELAY_W-1:0]       fine_aperture_delay,
    output var  logic                     sample_dual_edge,
    output var  logic                     ramp_step_pulse,
    output var  logic                     output_bus_clock,
    output var  logic                     output_bus_strobe
);
    // ==========================================================
    // register decode
    function automatic logic hit(input logic [`SCKDR_ADDR_W-1:0] a,
                                 input logic [`SCKDR_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    sckdr_ramp_state_type    ramp_state_reg;
    logic                    invert_reg;
    sckdr_mode_type          mode_reg;
    logic [DELAY_W-1:0]      target_reg;
    logic [DELAY_W-1:0]      active_reg;
    logic [DELAY_W-1:0]      fine_reg;
    logic                    delay_ramp_enable;
    logic                    delay_ramp_rate_select;
    logic [DEMUX_W-1:0]      output_demux_setting;
    logic [FRAME_W-1:0]      frame_length_setting;
    logic [8:0]              period_reg;
    logic                    ref_sync;
    logic                    ref_prev_reg;
    logic                    ref_event;
    logic                    ref_seen_reg;
    logic                    coarse_wr;
    logic [DELAY_W-1:0]      step_size;
    logic [DELAY_W-1:0]      gap;
    logic [DELAY_W-1:0]      active_next;

    assign coarse_wr = reg_write && hit(reg_addr, `SCKDR_OFF_COARSE);

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            invert_reg             <= 1'b0;
            mode_reg               <= SCKDR_MODE_DUAL_CHANNEL;
            fine_reg               <= `SCKDR_RST_FINE;
            delay_ramp_enable      <= 1'b0;
            delay_ramp_rate_select <= 1'b0;
            output_demux_setting   <= `SCKDR_RST_DEMUX;
            frame_length_setting   <= `SCKDR_RST_FRAME;
        end
        else if (reg_write)
        begin
            if (hit(reg_addr, `SCKDR_OFF_DELAY_CTRL))
            begin
                invert_reg <= reg_wdata[`SCKDR_BIT_INVERT];
                mode_reg   <= reg_wdata[`SCKDR_BIT_DUAL_EDGE] ? SCKDR_MODE_SINGLE_CHANNEL
                                                             : SCKDR_MODE_DUAL_CHANNEL;
                // demux sits here because the frame length fills its whole word
                output_demux_setting <= reg_wdata[`SCKDR_LSB_DEMUX +: DEMUX_W];
            end
            else if (hit(reg_addr, `SCKDR_OFF_FINE))
                fine_reg <= reg_wdata[DELAY_W-1:0];
            else if (hit(reg_addr, `SCKDR_OFF_RAMP_CTRL))
            begin
                delay_ramp_enable      <= reg_wdata[`SCKDR_BIT_RAMP_EN];
                delay_ramp_rate_select <= reg_wdata[`SCKDR_BIT_RAMP_FAST];
            end
            else if (hit(reg_addr, `SCKDR_OFF_FRAME_CTRL))
                frame_length_setting <= reg_wdata[FRAME_W-1:0];
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            target_reg <= `SCKDR_RST_COARSE;
        else if (coarse_wr)
            target_reg <= reg_wdata[DELAY_W-1:0];
    end

    // ==========================================================
    // coarse ramp
    assign step_size = delay_ramp_rate_select ? `SCKDR_FAST_STEPS : `SCKDR_SLOW_STEPS;
    assign gap       = (active_reg > target_reg) ? active_reg - target_reg
                                                 : target_reg - active_reg;

    always_comb
    begin
        // never overshoot: the last step may be shorter than the rate
        if (gap <= step_size)
            active_next = target_reg;
        else if (active_reg > target_reg)
            active_next = active_reg - step_size;
        else
            active_next = active_reg + step_size;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            ramp_state_reg <= SCKDR_RAMP_IDLE;
            period_reg     <= '0;
        end
        else if (coarse_wr && delay_ramp_enable)
        begin
            ramp_state_reg <= SCKDR_RAMP_WAIT;
            period_reg     <= '0;
        end
        else
        begin
            case (ramp_state_reg)
                SCKDR_RAMP_IDLE:
                    period_reg <= '0;
                SCKDR_RAMP_WAIT:
                begin
                    period_reg <= period_reg + 1'b1;
                    if (!delay_ramp_enable || active_reg == target_reg)
                        ramp_state_reg <= SCKDR_RAMP_IDLE;
                    else if (period_reg == `SCKDR_RAMP_PERIOD - 2'h2)
                        ramp_state_reg <= SCKDR_RAMP_STEP;
                end
                SCKDR_RAMP_STEP:
                begin
                    period_reg     <= '0;
                    ramp_state_reg <= (active_next == target_reg) ? SCKDR_RAMP_IDLE
                                                                  : SCKDR_RAMP_WAIT;
                end
                default:
                    ramp_state_reg <= SCKDR_RAMP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            active_reg <= `SCKDR_RST_COARSE;
        else if (coarse_wr && !delay_ramp_enable)
            active_reg <= reg_wdata[DELAY_W-1:0];
        else if (!delay_ramp_enable)
            active_reg <= target_reg;
        else if (ramp_state_reg == SCKDR_RAMP_STEP && !coarse_wr)
            active_reg <= active_next;
    end

    // ==========================================================
    // delay stage outputs; each field drives its own stage so they add
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            clock_invert_delay    <= 1'b0;
            coarse_aperture_delay <= `SCKDR_RST_COARSE;
            fine_aperture_delay   <= `SCKDR_RST_FINE;
            sample_dual_edge      <= 1'b0;
            ramp_step_pulse       <= 1'b0;
        end
        else
        begin
            clock_invert_delay    <= invert_reg;
            coarse_aperture_delay <= active_reg;
            fine_aperture_delay   <= fine_reg;
            sample_dual_edge      <= (mode_reg == SCKDR_MODE_SINGLE_CHANNEL);
            ramp_step_pulse       <= (ramp_state_reg == SCKDR_RAMP_STEP) && !coarse_wr;
        end
    end

    // ==========================================================
    // reference capture, on the same (delayed) clock edge every time
    sckdr_sync2 u_ref_sync
    (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .async_in (system_reference),
        .sync_out (ref_sync)
    );

    // a rising edge counts, so one pulse or a periodic train both work
    assign ref_event = ref_sync && !ref_prev_reg;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            ref_prev_reg <= 1'b0;
            ref_seen_reg <= 1'b0;
        end
        else
        begin
            ref_prev_reg <= ref_sync;
            // set wins over a read-clear in the same cycle
            if (ref_event)
                ref_seen_reg <= 1'b1;
            else if (reg_read && hit(reg_addr, `SCKDR_OFF_STATUS))
                ref_seen_reg <= 1'b0;
        end
    end

    // output bus timing runs on this same clock
    sckdr_strobe_gen #(.DEMUX_W(DEMUX_W), .FRAME_W(FRAME_W)) u_strobe
    (
        .clock                (clock),
        .sys_rst              (sys_rst),
        .ref_event            (ref_event),
        .output_demux_setting (output_demux_setting),
        .frame_length_setting (frame_length_setting),
        .output_bus_clock     (output_bus_clock),
        .output_bus_strobe    (output_bus_strobe)
    );

    // ==========================================================
    // read port
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            reg_rdata <= '0;
        else if (!reg_read)
            reg_rdata <= '0;
        else if (hit(reg_addr, `SCKDR_OFF_DELAY_CTRL))
            reg_rdata <= DATA_W'({output_demux_setting,
                                  (mode_reg == SCKDR_MODE_SINGLE_CHANNEL), invert_reg});
        else if (hit(reg_addr, `SCKDR_OFF_COARSE))
            reg_rdata <= DATA_W'(target_reg);
        else if (hit(reg_addr, `SCKDR_OFF_FINE))
            reg_rdata <= DATA_W'(fine_reg);
        else if (hit(reg_addr, `SCKDR_OFF_RAMP_CTRL))
            reg_rdata <= DATA_W'({delay_ramp_rate_select, delay_ramp_enable});
        else if (hit(reg_addr, `SCKDR_OFF_FRAME_CTRL))
            reg_rdata <= DATA_W'(frame_length_setting);
        else if (hit(reg_addr, `SCKDR_OFF_STATUS))
            reg_rdata <= DATA_W'({ref_seen_reg, (ramp_state_reg != SCKDR_RAMP_IDLE)});
        else if (hit(reg_addr, `SCKDR_OFF_ACTIVE))
            reg_rdata <= DATA_W'(active_reg);
        else
            reg_rdata <= '0;
    end

    // ==========================================================
    // checks
    ramp_rate_gap_a: assert property (@(posedge clock) disable iff (sys_rst)
        ramp_step_pulse |-> ##1 !ramp_step_pulse [*8])
        else $error("ramp steps too close together");
    ramp_bounded_a: assert property (@(posedge clock) disable iff (sys_rst)
        (ramp_state_reg == SCKDR_RAMP_STEP && !coarse_wr) |=>
        (gap < $past(gap)))
        else $error("ramp moved away from target");
    direct_write_a: assert property (@(posedge clock) disable iff (sys_rst)
        (coarse_wr && !delay_ramp_enable) |-> ##2 coarse_aperture_delay == $past(reg_wdata[DELAY_W-1:0], 2))
        else $error("direct coarse write not applied");
    ramp_restart_a: assert property (@(posedge clock) disable iff (sys_rst)
        (coarse_wr && delay_ramp_enable) |=> ramp_state_reg == SCKDR_RAMP_WAIT)
        else $error("coarse write did not restart ramp");
    ramp_stop_a: assert property (@(posedge clock) disable iff (sys_rst)
        (ramp_state_reg == SCKDR_RAMP_IDLE && !coarse_wr && delay_ramp_enable) |=> $stable(active_reg))
        else $error("coarse moved while idle");
    invert_follow_a: assert property (@(posedge clock) disable iff (sys_rst)
        (reg_write && hit(reg_addr, `SCKDR_OFF_DELAY_CTRL)) |-> ##2
        clock_invert_delay == $past(reg_wdata[`SCKDR_BIT_INVERT], 2))
        else $error("invert control not applied");
    ref_strobe_a: assert property (@(posedge clock) disable iff (sys_rst)
        ref_event |=> output_bus_strobe && !output_bus_clock)
        else $error("reference did not realign strobe");
    fine_follow_a: assert property (@(posedge clock) disable iff (sys_rst)
        (reg_write && hit(reg_addr, `SCKDR_OFF_FINE)) |-> ##2
        fine_aperture_delay == $past(reg_wdata[DELAY_W-1:0], 2))
        else $error("fine delay not applied");
endmodule
`default_nettype wire

/* src/sckdr_strobe_gen.sv */
// frame divider and output strobe generation, realigned by the reference event
`timescale 1ns/1ps
`default_nettype none
module sckdr_strobe_gen
#(
    parameter int DEMUX_W = 2,
    parameter int FRAME_W = 8
)
(
    input  wire logic               clock,
    input  wire logic               sys_rst,
    input  wire logic               ref_event,
    input  wire logic [DEMUX_W-1:0] output_demux_setting,
    input  wire logic [FRAME_W-1:0] frame_length_setting,
    output var  logic               output_bus_clock,
    output var  logic               output_bus_strobe
);
    localparam int CNT_W = DEMUX_W + FRAME_W + 1;

    logic [CNT_W-1:0] frame_len;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;

    assign frame_len = CNT_W'((output_demux_setting + 1'b1) * frame_length_setting);

    always_comb
    begin
        if (ref_event || (count_reg + 1'b1 >= frame_len))
            count_next = '0;
        else
            count_next = count_reg + 1'b1;
    end

    // divider and strobe restart on the reference so every device lines up
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            count_reg <= '0;
        else
            count_reg <= count_next;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            output_bus_clock  <= 1'b0;
            output_bus_strobe <= 1'b0;
        end
        else
        begin
            output_bus_clock  <= ref_event ? 1'b0 : ~output_bus_clock;
            output_bus_strobe <= (count_next == '0);
        end
    end
endmodule
`default_nettype wire

/* src/sckdr_sync2.sv */
// two-flop synchroniser for a level arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sckdr_sync2
(
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic async_in,
    output var  logic sync_out
);
    logic meta_reg;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule
`default_nettype wire

/* tb/sckdr_ref_gen.sv */
// model of the external reference generator feeding the clock delay ramp block
`timescale 1ns/1ps
`default_nettype none
module sckdr_ref_gen
(
    input  wire logic       clock,
    input  wire logic       pulse_req,
    input  wire logic       periodic_en,
    input  wire logic [7:0] period_cycles,
    output var  logic       system_reference
);
    logic [7:0] cnt_reg;
    logic [1:0] hold_reg;

    initial
    begin
        cnt_reg          = 8'h00;
        hold_reg         = 2'h0;
        system_reference = 1'b0;
    end

    // ==========================================================
    // reference drive
    // changes only just after a rising edge, so the capturing edge always sees a settled level
    always @(posedge clock)
    begin
        if (periodic_en)
        begin
            cnt_reg          <= (cnt_reg + 8'h01 >= period_cycles) ? 8'h00 : cnt_reg + 8'h01;
            system_reference <= (cnt_reg < (period_cycles >> 1));
        end
        else
        begin
            // a lone pulse is held for a few cycles so the synchroniser cannot miss it
            hold_reg         <= pulse_req ? 2'h2 : (hold_reg != 2'h0 ? hold_reg - 2'h1 : 2'h0);
            cnt_reg          <= 8'h00;
            system_reference <= pulse_req || (hold_reg != 2'h0);
        end
    end
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking testbench of the clock delay ramp block
`timescale 1ns/1ps
`default_nettype none
`include "sckdr_regs.svh"
module tb;
    import sckdr_pkg::*;

    localparam int CYC_LIMIT = 12000;

    logic       clock = 1'b0;
    logic       sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_write = 1'b0;
    logic       reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic       system_reference;
    logic       clock_invert_delay;
    logic [7:0] coarse_aperture_delay;
    logic [7:0] fine_aperture_delay;
    logic       sample_dual_edge;
    logic       ramp_step_pulse;
    logic       output_bus_clock;
    logic       output_bus_strobe;
    logic       pulse_req = 1'b0;
    logic       periodic_en = 1'b0;
    logic [7:0] period_cycles = 8'h08;
    int         bad_count = 0;
    int         samples_checked = 0;
    int         cyc_count = 0;
    int         n;
    logic [7:0] d;
    logic       a;

    always #12.5 clock = ~clock;

    sckdr_delay_ramp u_sckdr_delay_ramp
    (
        .clock                 (clock),
        .sys_rst               (sys_rst),
        .reg_addr              (reg_addr),
        .reg_wdata             (reg_wdata),
        .reg_write             (reg_write),
        .reg_read              (reg_read),
        .reg_rdata             (reg_rdata),
        .system_reference      (system_reference),
        .clock_invert_delay    (clock_invert_delay),
        .coarse_aperture_delay (coarse_aperture_delay),
        .fine_aperture_delay   (fine_aperture_delay),
        .sample_dual_edge      (sample_dual_edge),
        .ramp_step_pulse       (ramp_step_pulse),
        .output_bus_clock      (output_bus_clock),
        .output_bus_strobe     (output_bus_strobe)
    );

    sckdr_ref_gen u_sckdr_ref_gen
    (
        .clock            (clock),
        .pulse_req        (pulse_req),
        .periodic_en      (periodic_en),
        .period_cycles    (period_cycles),
        .system_reference (system_reference)
    );

    // ==========================================================
    // helpers
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] addr, input logic [7:0] data);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr  <= addr;
        reg_wdata <= data;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] addr, output logic [7:0] data);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= addr;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        data = reg_rdata;
    endtask

    // settle two edges so a register write has reached the delay outputs
    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask

    task automatic wait_step(input int max, output int cnt);
        cnt = 0;
        do
        begin
            @(posedge clock);
            #1;
            cnt++;
        end while (ramp_step_pulse !== 1'b1 && cnt < max);
        // the delay output follows the step pulse by one edge
        if (ramp_step_pulse === 1'b1)
        begin
            @(posedge clock);
            #1;
            cnt++;
        end
    endtask

    task automatic wait_strobe(input int max, output int cnt);
        cnt = 0;
        do
        begin
            @(posedge clock);
            #1;
            cnt++;
        end while (output_bus_strobe !== 1'b1 && cnt < max);
    endtask

    always @(posedge clock)
    begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == CYC_LIMIT)
        begin
            bad_count++;
            print_verdict();
        end
    end

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        #1;
        chk(coarse_aperture_delay, 8'h00);
        rd(`SCKDR_OFF_FRAME_CTRL, d);
        chk(d, `SCKDR_RST_FRAME);
        // unmapped place: write ignored, read zero, data stands one cycle only
        wr(4'hf, 8'haa);
        rd(4'hf, d);
        chk(d, 8'h00);
        rd(`SCKDR_OFF_FINE, d);
        chk(d, `SCKDR_RST_FINE);
        @(posedge clock);
        #1;
        chk(reg_rdata, 8'h00);
        // every mode and inversion combination
        for (int m = 0; m < 4; m++)
        begin
            wr(`SCKDR_OFF_DELAY_CTRL, 8'(m));
            settle();
            chk({7'h0, clock_invert_delay}, 8'(m & 1));
            chk({7'h0, sample_dual_edge}, 8'(m >> 1));
        end
        // stages are independent and reach the top setting
        wr(`SCKDR_OFF_FINE, 8'hff);
        settle();
        chk(fine_aperture_delay, 8'hff);
        chk(coarse_aperture_delay, 8'h00);
        chk({7'h0, clock_invert_delay}, 8'h01);
        wr(`SCKDR_OFF_COARSE, 8'hff);
        settle();
        chk(coarse_aperture_delay, 8'hff);
        chk(fine_aperture_delay, 8'hff);
        wr(`SCKDR_OFF_COARSE, 8'h00);
        settle();
        chk(coarse_aperture_delay, 8'h00);
        // the output bus clock runs off the device clock
        a = output_bus_clock;
        @(posedge clock);
        #1;
        chk({7'h0, output_bus_clock}, {7'h0, ~a});
        // slow ramp, one step per period
        wr(`SCKDR_OFF_RAMP_CTRL, 8'h01);
        wr(`SCKDR_OFF_COARSE, 8'h03);
        settle();
        chk(coarse_aperture_delay, 8'h00);
        rd(`SCKDR_OFF_STATUS, d);
        chk(d & 8'h01, 8'h01);
        for (int k = 1; k <= 3; k++)
        begin
            wait_step(600, n);
            chk(coarse_aperture_delay, 8'(k));
            if (k > 1)
                chk(8'(n - 1), 8'(`SCKDR_RAMP_PERIOD - 1));
        end
        wait_step(300, n);
        chk(8'(n), 8'(300));
        rd(`SCKDR_OFF_STATUS, d);
        chk(d & 8'h01, 8'h00);
        // fast ramp, four per period, last step clipped
        wr(`SCKDR_OFF_RAMP_CTRL, 8'h03);
        wr(`SCKDR_OFF_COARSE, 8'h0d);
        wait_step(600, n);
        chk(coarse_aperture_delay, 8'h07);
        wait_step(600, n);
        chk(coarse_aperture_delay, 8'h0b);
        chk(8'(n - 1), 8'(`SCKDR_RAMP_PERIOD - 1));
        wait_step(600, n);
        chk(coarse_aperture_delay, 8'h0d);
        // a new write in mid-ramp retargets the walk
        wr(`SCKDR_OFF_COARSE, 8'h00);
        wait_step(600, n);
        chk(coarse_aperture_delay, 8'h09);
        wr(`SCKDR_OFF_COARSE, 8'h0c);
        wait_step(600, n);
        chk(coarse_aperture_delay, 8'h0c);
        wait_step(300, n);
        chk(8'(n), 8'(300));
        rd(`SCKDR_OFF_ACTIVE, d);
        chk(d, 8'h0c);
        rd(`SCKDR_OFF_COARSE, d);
        chk(d, 8'h0c);
        // lone reference pulse realigns the strobe
        rd(`SCKDR_OFF_STATUS, d);
        @(posedge clock);
        pulse_req <= 1'b1;
        @(posedge clock);
        pulse_req <= 1'b0;
        // two synchroniser edges plus the strobe output register: the strobe restarts on the third edge
        repeat (3) @(posedge clock);
        #1;
        chk({7'h0, output_bus_strobe}, 8'h01);
        chk({7'h0, output_bus_clock}, 8'h00);
        wait_strobe(20, n);
        chk(8'(n), 8'h04);
        rd(`SCKDR_OFF_STATUS, d);
        chk(d & 8'h02, 8'h02);
        rd(`SCKDR_OFF_STATUS, d);
        chk(d & 8'h02, 8'h00);
        // periodic reference at a legal rate for two frame lengths
        periodic_en <= 1'b1;
        repeat (40) @(posedge clock);
        wait_strobe(20, n);
        wait_strobe(20, n);
        chk(8'(n), 8'h04);
        wr(`SCKDR_OFF_FRAME_CTRL, 8'h06);
        period_cycles <= 8'h0c;
        repeat (40) @(posedge clock);
        wait_strobe(20, n);
        wait_strobe(20, n);
        chk(8'(n), 8'h06);
        // demux of one doubles the frame: (1 + 1) * 6 cycles
        wr(`SCKDR_OFF_DELAY_CTRL, 8'h04);
        rd(`SCKDR_OFF_DELAY_CTRL, d);
        chk(d, 8'h04);
        repeat (40) @(posedge clock);
        wait_strobe(30, n);
        wait_strobe(30, n);
        chk(8'(n), 8'h0c);
        print_verdict();
    end
endmodule
`default_nettype wire
